// >>> rtl/sfs_pkg.sv
// Package: register map, field layout and types of the SPI master frame sequencer
package sfs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  typedef logic [ADDR_W-1:0] sfs_addr_t;
  localparam sfs_addr_t OFF_CR0 = 8'h00;
  localparam sfs_addr_t OFF_CR1 = 8'h04;
  localparam sfs_addr_t OFF_DATA = 8'h08;
  localparam sfs_addr_t OFF_STATUS = 8'h0C;
  localparam sfs_addr_t OFF_PRESCALE = 8'h10;
  localparam sfs_addr_t OFF_IMASK = 8'h14;
  localparam sfs_addr_t OFF_RAW_IRQ = 8'h18;
  localparam sfs_addr_t OFF_MASKED_IRQ = 8'h1C;
  localparam sfs_addr_t OFF_IRQ_CLEAR = 8'h20;
  localparam sfs_addr_t OFF_DMA = 8'h24;
  localparam sfs_addr_t OFF_RX_COUNT = 8'h28;
  localparam sfs_addr_t OFF_FILL = 8'h2C;
  localparam sfs_addr_t OFF_TXQ_COUNT = 8'h30;
  localparam sfs_addr_t OFF_ITEST = 8'h80;
  localparam sfs_addr_t OFF_TEST_DATA = 8'h8C;

  // ----------------------------------------------------------------
  // Reset values, write masks and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] CR0_RESET = 32'h1C000000;
  localparam logic [31:0] CR0_WMASK = 32'h0580FFDF;
  localparam logic [31:0] CR1_RESET = 32'h00000000;
  localparam logic [31:0] CR1_WMASK = 32'h002FDFBE;
  localparam logic [31:0] ALL_WMASK = 32'hFFFFFFFF;
  localparam logic [31:0] PRESCALE_WMASK = 32'h000000FE;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam int CR0_LEN_LSB = 0;
  localparam int CR0_POL_BIT = 6;
  localparam int CR0_PHA_BIT = 7;
  localparam int CR0_RATE_LSB = 8;
  localparam int CR0_MODE_LSB = 23;
  localparam int CR0_CS1_BIT = 26;
  localparam int CR1_ENABLE_BIT = 1;
  localparam int CR1_ROLE_BIT = 2;
  localparam logic [4:0] LEN_MIN = 5'h03;
  localparam int SR_TX_EMPTY = 0;
  localparam int SR_TX_NOT_FULL = 1;
  localparam int SR_RX_NOT_EMPTY = 2;
  localparam int SR_RX_FULL = 3;
  localparam int SR_BUSY = 4;

  // ----------------------------------------------------------------
  // Queues, bus answers and encodings
  // ----------------------------------------------------------------
  localparam int QDEPTH = 8;
  localparam int QPTR_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] MODE_FULL = 2'h0;
  localparam logic [1:0] MODE_TX = 2'h1;
  localparam logic [1:0] MODE_RX = 2'h2;
  localparam logic [1:0] MODE_COMB = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } sfs_state_e;

  typedef enum logic [2:0] {
    PH_NONE = 3'b001,
    PH_TXQ = 3'b010,
    PH_FILL = 3'b100
  } sfs_phase_e;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
  } sfs_pins_s;

  // Address decode shared by the read and the write path
  function automatic logic sfs_mapped(input sfs_addr_t a);
    return a == OFF_CR0 || a == OFF_CR1 || a == OFF_DATA || a == OFF_STATUS || a == OFF_PRESCALE ||
           a == OFF_IMASK || a == OFF_RAW_IRQ || a == OFF_MASKED_IRQ || a == OFF_IRQ_CLEAR ||
           a == OFF_DMA || a == OFF_RX_COUNT || a == OFF_FILL || a == OFF_TXQ_COUNT ||
           a == OFF_ITEST || a == OFF_TEST_DATA;
  endfunction

  // Byte-lane merge; bits outside the mask keep their old value
  function automatic logic [31:0] sfs_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return (r & wmask) | (old & ~wmask);
  endfunction

endpackage

// >>> rtl/sfs_spi_master.sv
// SPI master frame sequencer with AXI4-Lite register slave, transmit and receive queues

// Notes on behaviour
// - Sequencing modes act only in master role
// - Mode 0: send queued words, keep replies
// - Mode 1: send queued words, discard replies
// - Mode 2 empty queue: fill, capture, decrement
// - Mode 2: queued words first, then fill
// - Counter zero after last frame halts
// - Receive count drops before frame, queue empty
// - Fill phase ignores newly queued words
// - Queue count drops before each word
// - Then fill frames until receive count zero
// - Combined mode stop conditions
// - Finish one counter before starting other
// - Every frame sent in modes 0, 2 and 3 captures the reply
// - Mode change applies at next word
// - Frame length is length field plus one; field values below 3 give four bits
// - Polarity bit sets idle clock level
// - Phase bit picks sampling edge
// - Rate is clock over prescale times rate plus one
// - Mode field at bits 24:23
// - Bit 26 drives slave select, resets high
// - Role bit: zero is master
// - Enable bit gates serial operation
module sfs_spi_master (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sfs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sfs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic miso,
  output sfs_pkg::sfs_pins_s spi_pins
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] cr0;
  logic [31:0] cr1;
  logic [31:0] prescale;
  logic [31:0] imask;
  logic [31:0] dma_ctl;
  logic [31:0] itest;
  logic [31:0] test_data;
  logic [31:0] fill_char;
  logic [31:0] rx_count;
  logic [31:0] txq_count;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  logic aw_have;
  logic w_have;
  sfs_pkg::sfs_addr_t aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Write fires once both halves are held and no response is pending
  wire wr_go = aw_have && w_have && !s_axi_bvalid;
  wire sfs_pkg::sfs_addr_t wr_a = {aw_addr[sfs_pkg::ADDR_W-1:2], 2'b00};
  wire sfs_pkg::sfs_addr_t rd_a = {s_axi_araddr[sfs_pkg::ADDR_W-1:2], 2'b00};
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire wr_cr0 = wr_go && wr_a == sfs_pkg::OFF_CR0;
  wire wr_cr1 = wr_go && wr_a == sfs_pkg::OFF_CR1;
  wire wr_data = wr_go && wr_a == sfs_pkg::OFF_DATA;
  wire wr_prescale = wr_go && wr_a == sfs_pkg::OFF_PRESCALE;
  wire wr_imask = wr_go && wr_a == sfs_pkg::OFF_IMASK;
  wire wr_dma = wr_go && wr_a == sfs_pkg::OFF_DMA;
  wire wr_rx_count = wr_go && wr_a == sfs_pkg::OFF_RX_COUNT;
  wire wr_fill = wr_go && wr_a == sfs_pkg::OFF_FILL;
  wire wr_txq_count = wr_go && wr_a == sfs_pkg::OFF_TXQ_COUNT;
  wire wr_itest = wr_go && wr_a == sfs_pkg::OFF_ITEST;
  wire wr_test_data = wr_go && wr_a == sfs_pkg::OFF_TEST_DATA;
  wire rd_data = rd_go && rd_a == sfs_pkg::OFF_DATA;

  // Handshake: one write and one read in flight at a time
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready = !w_have && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [4:0] len_field = cr0[sfs_pkg::CR0_LEN_LSB +: 5];
  // Reserved short lengths run as the shortest legal frame
  wire [4:0] len_m1 = (len_field < sfs_pkg::LEN_MIN) ? sfs_pkg::LEN_MIN : len_field;
  wire [7:0] rate_field = cr0[sfs_pkg::CR0_RATE_LSB +: 8];
  wire [1:0] mode = cr0[sfs_pkg::CR0_MODE_LSB +: 2];
  wire pha = cr0[sfs_pkg::CR0_PHA_BIT];
  wire pol = cr0[sfs_pkg::CR0_POL_BIT];
  // Master role and enable both required to start a frame
  wire can_run = cr1[sfs_pkg::CR1_ENABLE_BIT] && !cr1[sfs_pkg::CR1_ROLE_BIT];

  // Half bit period = (prescale / 2) * (1 + rate); prescale below 2 acts as 2
  wire [6:0] pre_half = (prescale[7:1] == 7'h00) ? 7'h01 : prescale[7:1];
  wire [15:0] half_len = 16'(pre_half) * (16'(rate_field) + 16'h0001);
  wire [15:0] half_m1 = half_len - 16'h0001;

  // ----------------------------------------------------------------
  // Transmit and receive queues
  // ----------------------------------------------------------------
  logic [31:0] txq_mem [sfs_pkg::QDEPTH];
  logic [31:0] rxq_mem [sfs_pkg::QDEPTH];
  logic [sfs_pkg::QPTR_W-1:0] txq_wp;
  logic [sfs_pkg::QPTR_W-1:0] txq_rp;
  logic [sfs_pkg::QPTR_W:0] txq_cnt;
  logic [sfs_pkg::QPTR_W-1:0] rxq_wp;
  logic [sfs_pkg::QPTR_W-1:0] rxq_rp;
  logic [sfs_pkg::QPTR_W:0] rxq_cnt;

  wire tx_empty = txq_cnt == '0;
  wire tx_full = txq_cnt == (sfs_pkg::QPTR_W+1)'(sfs_pkg::QDEPTH);
  wire rx_empty = rxq_cnt == '0;
  wire rx_full = rxq_cnt == (sfs_pkg::QPTR_W+1)'(sfs_pkg::QDEPTH);
  wire tx_ne = !tx_empty;

  // ----------------------------------------------------------------
  // Frame sequencing decision, taken only between frames
  // ----------------------------------------------------------------
  sfs_pkg::sfs_state_e state;
  sfs_pkg::sfs_phase_e phase;
  logic keep_reply;

  wire m_full = mode == sfs_pkg::MODE_FULL;
  wire m_tx = mode == sfs_pkg::MODE_TX;
  wire m_rx = mode == sfs_pkg::MODE_RX;
  wire m_comb = mode == sfs_pkg::MODE_COMB;
  wire rx_left = rx_count != '0;
  wire txq_left = txq_count != '0;
  // A counter that has started keeps the link until it runs out
  wire lock_fill = phase == sfs_pkg::PH_FILL && rx_left;
  wire lock_txq = phase == sfs_pkg::PH_TXQ && txq_left;

  // Receive mode: fill frames while locked or queue empty, else queued words
  wire rx_fill = m_rx && (lock_fill || (!tx_ne && rx_left));
  wire rx_word = m_rx && !rx_fill && tx_ne;
  // Combined mode: counted queue words, then counted fill frames
  wire cb_word = m_comb && !lock_fill && txq_left && tx_ne;
  wire cb_fill = m_comb && !txq_left && rx_left && (lock_fill || !tx_ne);
  wire plain_word = (m_full || m_tx) && tx_ne;
  wire sel_word = plain_word || rx_word || cb_word;
  wire sel_fill = rx_fill || cb_fill;
  wire need_reply = !m_tx;
  // Mode sampled here only, so a change mid-frame waits for the next word
  wire go = state == sfs_pkg::ST_IDLE && can_run && (sel_word || sel_fill) &&
            (!need_reply || !rx_full);
  wire dec_rx = go && sel_fill;
  wire dec_txq = go && cb_word;
  wire tx_pop = go && sel_word;
  wire [31:0] next_word = sel_word ? txq_mem[txq_rp] : fill_char;
  wire [4:0] load_shift = 5'h1F - len_m1;

  // ----------------------------------------------------------------
  // Shift engine timing
  // ----------------------------------------------------------------
  logic [15:0] tcnt;
  logic [5:0] hcnt;
  logic sclk_int;
  logic [31:0] tx_sh;
  logic [31:0] rx_sh;

  wire shifting = state == sfs_pkg::ST_SHIFT;
  wire tick = shifting && tcnt == half_m1;
  wire lead = tick && !hcnt[0];
  wire trail = tick && hcnt[0];
  wire last_half = hcnt == {len_m1, 1'b1};
  // Phase 0 samples on leading edges, phase 1 on trailing edges
  wire sample = pha ? trail : lead;
  wire shift_out = pha ? (lead && hcnt != 6'h00) : (trail && !last_half);
  wire rx_push = state == sfs_pkg::ST_DONE && keep_reply && !rx_full;
  wire rx_pop = rd_data && !rx_empty;
  wire tx_push = wr_data && !tx_full;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  wire [31:0] status_word = {27'h0, state != sfs_pkg::ST_IDLE, rx_full, !rx_empty, !tx_full, tx_empty};
  wire [31:0] rd_word =
    (rd_a == sfs_pkg::OFF_CR0) ? cr0 :
    (rd_a == sfs_pkg::OFF_CR1) ? cr1 :
    (rd_a == sfs_pkg::OFF_DATA) ? (rx_empty ? sfs_pkg::ZERO_WORD : rxq_mem[rxq_rp]) :
    (rd_a == sfs_pkg::OFF_STATUS) ? status_word :
    (rd_a == sfs_pkg::OFF_PRESCALE) ? prescale :
    (rd_a == sfs_pkg::OFF_IMASK) ? imask :
    (rd_a == sfs_pkg::OFF_DMA) ? dma_ctl :
    (rd_a == sfs_pkg::OFF_RX_COUNT) ? rx_count :
    (rd_a == sfs_pkg::OFF_FILL) ? fill_char :
    (rd_a == sfs_pkg::OFF_TXQ_COUNT) ? txq_count :
    (rd_a == sfs_pkg::OFF_ITEST) ? itest :
    (rd_a == sfs_pkg::OFF_TEST_DATA) ? test_data : sfs_pkg::ZERO_WORD;

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sfs_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= sfs_pkg::sfs_mapped(wr_a) ? sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read response, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sfs_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= sfs_pkg::sfs_mapped(rd_a) ? sfs_pkg::RESP_OKAY : sfs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers; reserved bits hold their reset value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cr0 <= sfs_pkg::CR0_RESET;
      cr1 <= sfs_pkg::CR1_RESET;
      prescale <= '0;
      imask <= '0;
      dma_ctl <= '0;
      itest <= '0;
      test_data <= '0;
      fill_char <= '0;
    end else begin
      if (wr_cr0) cr0 <= sfs_pkg::sfs_merge(cr0, w_data, w_strb, sfs_pkg::CR0_WMASK);
      if (wr_cr1) cr1 <= sfs_pkg::sfs_merge(cr1, w_data, w_strb, sfs_pkg::CR1_WMASK);
      if (wr_prescale) prescale <= sfs_pkg::sfs_merge(prescale, w_data, w_strb, sfs_pkg::PRESCALE_WMASK);
      if (wr_imask) imask <= sfs_pkg::sfs_merge(imask, w_data, w_strb, sfs_pkg::ALL_WMASK);
      if (wr_dma) dma_ctl <= sfs_pkg::sfs_merge(dma_ctl, w_data, w_strb, sfs_pkg::ALL_WMASK);
      if (wr_itest) itest <= sfs_pkg::sfs_merge(itest, w_data, w_strb, sfs_pkg::ALL_WMASK);
      if (wr_test_data) test_data <= sfs_pkg::sfs_merge(test_data, w_data, w_strb, sfs_pkg::ALL_WMASK);
      if (wr_fill) fill_char <= sfs_pkg::sfs_merge(fill_char, w_data, w_strb, sfs_pkg::ALL_WMASK);
    end
  end

  // Frame counters: a software reload wins over a same-cycle decrement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_count <= '0;
      txq_count <= '0;
    end else begin
      if (wr_rx_count) begin
        rx_count <= sfs_pkg::sfs_merge(rx_count, w_data, w_strb, sfs_pkg::ALL_WMASK);
      end else if (dec_rx) begin
        rx_count <= rx_count - 32'h00000001;
      end
      if (wr_txq_count) begin
        txq_count <= sfs_pkg::sfs_merge(txq_count, w_data, w_strb, sfs_pkg::ALL_WMASK);
      end else if (dec_txq) begin
        txq_count <= txq_count - 32'h00000001;
      end
    end
  end

  // Transmit queue; writes to a full queue are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txq_wp <= '0;
      txq_rp <= '0;
      txq_cnt <= '0;
    end else begin
      if (tx_push) txq_wp <= txq_wp + 1'b1;
      if (tx_pop) txq_rp <= txq_rp + 1'b1;
      txq_cnt <= txq_cnt + (sfs_pkg::QPTR_W+1)'(tx_push) - (sfs_pkg::QPTR_W+1)'(tx_pop);
    end
  end

  // Queue storage needs no reset
  always_ff @(posedge aclk) begin
    if (tx_push) txq_mem[txq_wp] <= w_data;
    if (rx_push) rxq_mem[rxq_wp] <= rx_sh;
  end

  // Receive queue; a data read pops one word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxq_wp <= '0;
      rxq_rp <= '0;
      rxq_cnt <= '0;
    end else begin
      if (rx_push) rxq_wp <= rxq_wp + 1'b1;
      if (rx_pop) rxq_rp <= rxq_rp + 1'b1;
      rxq_cnt <= rxq_cnt + (sfs_pkg::QPTR_W+1)'(rx_push) - (sfs_pkg::QPTR_W+1)'(rx_pop);
    end
  end

  // Frame state and active counter phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= sfs_pkg::ST_IDLE;
      phase <= sfs_pkg::PH_NONE;
      keep_reply <= 1'b0;
    end else begin
      unique case (state)
        sfs_pkg::ST_IDLE: begin
          if (go) begin
            state <= sfs_pkg::ST_SHIFT;
            keep_reply <= need_reply;
            phase <= sel_fill ? sfs_pkg::PH_FILL : (cb_word ? sfs_pkg::PH_TXQ : sfs_pkg::PH_NONE);
          end
        end
        sfs_pkg::ST_SHIFT: begin
          if (tick && last_half) state <= sfs_pkg::ST_DONE;
        end
        sfs_pkg::ST_DONE: begin
          state <= sfs_pkg::ST_IDLE;
          // Spent counter frees the link, so a later reload cannot resume a stale lock
          if (!lock_fill && !lock_txq) phase <= sfs_pkg::PH_NONE;
        end
        default: begin
          state <= sfs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bit timing; the clock toggles only inside a frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tcnt <= '0;
      hcnt <= '0;
      sclk_int <= 1'b0;
    end else if (!shifting) begin
      tcnt <= '0;
      hcnt <= '0;
      sclk_int <= 1'b0;
    end else if (tick) begin
      tcnt <= '0;
      hcnt <= hcnt + 6'h01;
      sclk_int <= !sclk_int;
    end else begin
      tcnt <= tcnt + 16'h0001;
    end
  end

  // Shift registers, most significant bit first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh <= '0;
      rx_sh <= '0;
    end else if (go) begin
      tx_sh <= next_word << load_shift;
      rx_sh <= '0;
    end else begin
      if (shift_out) tx_sh <= {tx_sh[30:0], 1'b0};
      if (sample) rx_sh <= {rx_sh[30:0], miso};
    end
  end

  // Serial pins; select follows its control bit directly
  assign spi_pins.sclk = sclk_int ^ pol;
  assign spi_pins.mosi = tx_sh[31];
  assign spi_pins.cs_n = cr0[sfs_pkg::CR0_CS1_BIT];

endmodule

// >>> tb/sfs_slave_model.sv
// Slave model: inverted echo of the master output, bit logger
module sfs_slave_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic lead_high,
  output logic miso,
  output logic [31:0] heard,
  output int unsigned edges
);
  timeunit 1ns;
  timeprecision 1ns;
  // Echo makes every reply predictable; released line shows the inverse of its last level
  assign miso = cs_n ? heard[0] : ~mosi;
  initial begin
    heard = 32'h0;
    edges = 0;
  end
  // Edge toward the lead_high level takes one bit, MSB first
  always @(sclk) begin
    if (sclk == lead_high && !cs_n) begin
      heard = {heard[30:0], mosi};
      edges++;
    end
  end
endmodule

// >>> tb/sfs_spi_master_sva.sv
// Checker: bus handshake timing and select pin of the sequencer
module sfs_spi_master_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sfs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sfs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire sfs_pkg::sfs_pins_s spi_pins
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  property p_wr_hold; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_wr_ok; s_wr_take ##0 (s_axi_awaddr == 8'h00) |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h0; endproperty
  property p_wr_err; s_wr_take ##0 (s_axi_awaddr == 8'h40) |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2; endproperty
  property p_b_clear; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_rd_lat; s_rd_take |=> s_axi_rvalid; endproperty
  property p_rd_err; s_rd_take ##0 (s_axi_araddr == 8'h40) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
  property p_rd_hold; s_axi_rvalid |-> !s_axi_arready; endproperty
  // Select pin is register driven, so it moves only with a write
  property p_cs_write; $changed(spi_pins.cs_n) |-> $rose(s_axi_bvalid); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write taken while answer pending");
  a_wr_ok: assert property (p_wr_ok) else $error("write answer late or wrong");
  a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
  a_b_clear: assert property (p_b_clear) else $error("write answer not cleared");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  a_rd_hold: assert property (p_rd_hold) else $error("read taken while answer pending");
  a_cs_write: assert property (p_cs_write) else $error("select moved without write");
endmodule
bind sfs_spi_master sfs_spi_master_sva u_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .spi_pins);

// >>> tb/test_spi_master_frame_sequencer.sv
// Testbench: register bus and frame sequencing of the SPI sequencer
module test_spi_master_frame_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, miso;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, heard, rd, f, w[3];
  sfs_pkg::sfs_pins_s spi_pins;
  int unsigned edges, base, per;
  logic lead_high;
  int failures, checks_done;
  sfs_spi_master dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .miso, .spi_pins);
  sfs_slave_model slave (.sclk(spi_pins.sclk), .mosi(spi_pins.mosi), .cs_n(spi_pins.cs_n), .lead_high,
    .miso, .heard, .edges);
  // ------
  // Helpers
  // ------
  // Echo slave answers an 8-bit frame with its inverse
  function automatic logic [31:0] reply(input logic [31:0] sent);
    return ~sent & 32'h000000FF;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Each channel held until its ready is seen high at a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic hb;
    hb = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!hb) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      hb = s_axi_bvalid;
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    logic hr;
    hr = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!hr) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
    end
    s_axi_rready <= 1'h0;
  endtask
  // Eight-bit frames, slave selected, mode m
  task automatic cfg(input logic [1:0] m);
    wr(8'h00, {7'h00, m, 23'h000007});
  endtask
  task automatic pop(input logic [31:0] sent);
    rdr(8'h08, rd);
    chk("rx word", reply(sent), rd);
  endtask
  // Bounded wait for n more bits; the idle tail would expose a stray frame
  task automatic bits(input int unsigned n);
    int t;
    t = 0;
    while (edges < base + n && t < 3000) begin
      @(posedge aclk);
      t++;
    end
    repeat (10) @(posedge aclk);
    base = base + n;
    chk("bit count", base, edges);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Clock
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    close_out();
  end
  // ------
  // Tests
  // ------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    base = 0;
    lead_high = 1'h1;
    failures = 0;
    checks_done = 0;
    void'($urandom(97969));
    for (int i = 0; i < 3; i++) begin
      w[i] = $urandom();
    end
    f = $urandom();
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(8'h00, rd);
    chk("control0", 32'h1C000000, rd);
    chk("select", 32'h1, spi_pins.cs_n);
    wr(8'h0C, 32'h0);
    wr(8'h40, 32'h5);
    rdr(8'h40, rd);
    chk("unmapped", 32'h0, rd);
    rdr(8'h0C, rd);
    chk("status", 32'h3, rd);
    wr(8'h00, 32'h04000040);
    chk("idle high", 32'h1, spi_pins.sclk);
    $display("test registers done");
    wr(8'h10, 32'h2);
    cfg(2'h0);
    wr(8'h04, 32'h6);
    for (int i = 0; i < 3; i++) begin
      wr(8'h08, w[i]);
    end
    repeat (40) @(posedge aclk);
    chk("slave role", 32'h0, edges);
    wr(8'h04, 32'h2);
    bits(24);
    chk("mosi word", w[2] & 32'hFF, heard & 32'hFF);
    for (int i = 0; i < 3; i++) begin
      pop(w[i]);
    end
    $display("test full duplex done");
    // Phase one, rate one: slave takes bits on falling edges, half period two cycles
    wr(8'h00, 32'h00000187);
    lead_high <= 1'h0;
    wr(8'h08, w[1]);
    while (edges < base + 1) @(posedge aclk);
    per = 0;
    while (edges < base + 2) begin
      @(posedge aclk);
      per++;
    end
    chk("bit period", 32'h4, per);
    bits(8);
    pop(w[1]);
    chk("mosi phase1", w[1] & 32'hFF, heard & 32'hFF);
    lead_high <= 1'h1;
    $display("test phase done");
    cfg(2'h1);
    wr(8'h08, w[0]);
    wr(8'h08, w[1]);
    bits(16);
    rdr(8'h0C, rd);
    chk("rx empty", 32'h0, rd & 32'h4);
    $display("test transmit done");
    cfg(2'h2);
    wr(8'h08, w[0]);
    wr(8'h2C, f);
    wr(8'h28, 32'h3);
    bits(32);
    rdr(8'h28, rd);
    chk("rx count", 32'h0, rd);
    pop(w[0]);
    repeat (3) pop(f);
    chk("fill sent", f & 32'hFF, heard & 32'hFF);
    repeat (60) @(posedge aclk);
    chk("halted", base, edges);
    chk("idle low", 32'h0, spi_pins.sclk);
    $display("test receive done");
    cfg(2'h3);
    wr(8'h08, w[1]);
    wr(8'h08, w[2]);
    wr(8'h28, 32'h1);
    wr(8'h30, 32'h2);
    bits(24);
    rdr(8'h30, rd);
    chk("queue count", 32'h0, rd);
    pop(w[1]);
    pop(w[2]);
    pop(f);
    $display("test combined done");
    close_out();
  end
endmodule
